// ---- src/nfc_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer; full throughput with registered ready.
module nfc_buf2 #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic push;
        logic pop;
        push = in_valid && (cnt_q != 2'd2);
        pop = (cnt_q != 2'd0) && out_ready;
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    assign in_ready = (cnt_q != 2'd2);
    assign out_valid = (cnt_q != 2'd0);
    assign out_data = mem_q[rd_q];
endmodule // nfc_buf2
`default_nettype wire

// ---- src/nfc_host.sv ----
// Functional notes
// - Bytes written by write strobe pulse, chip selected
// - Command/address latch strobes qualify written bytes
// - Three address cycles for read and program: column, row low, row high
// - Program 80h, address, data, 10h; reads addressed
// - Erase 60h, two row cycles, D0h
// - Spare read 50h needs spare enable low
// - Spare enable high blocks spare; keep static
`timescale 1ns/1ps
`default_nettype none
module nfc_host
    import nfc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // User request port
    input wire logic req_valid,
    output logic req_ready,
    input wire nfc_req_t req,
    // Write data toward the flash
    input wire logic wdata_valid,
    output logic wdata_ready,
    input wire logic [7:0] wdata,
    // Read data from the flash
    output logic rdata_valid,
    input wire logic rdata_ready,
    output logic [7:0] rdata,
    output logic done,
    // Flash pins
    output nfc_pins_t pins,
    output logic [7:0] byte_port_o,
    output logic byte_port_oe,
    input wire logic [7:0] byte_port_i,
    input wire logic ready_busy_n
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_CMD = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_WDATA = 4'b0011,
        ST_CMD2 = 4'b0100,
        ST_WAIT_BSY = 4'b0101,
        ST_WAIT_RDY = 4'b0110,
        ST_RDATA = 4'b0111,
        ST_PUSH = 4'b1000,
        ST_FINISH = 4'b1001
    } nfc_state_t;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] bp_s1_q, bp_s2_q;
    logic rb_s1_q, rb_s2_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bp_s1_q <= 8'h00;
            bp_s2_q <= 8'h00;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
        end else begin
            bp_s1_q <= byte_port_i;
            bp_s2_q <= bp_s1_q;
            rb_s1_q <= ready_busy_n;
            rb_s2_q <= rb_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    nfc_state_t st_q, st_d;
    nfc_req_t r_q, r_d;
    nfc_pins_t pin_q, pin_d;
    logic [7:0] out_q, out_d;
    logic oe_q, oe_d;
    logic [1:0] idx_q, idx_d;    // address cycle index
    logic [3:0] tmr_q, tmr_d;    // strobe phase timer
    logic ph_q, ph_d;            // 0 = strobe low, 1 = strobe high
    logic [9:0] left_q, left_d;
    logic done_q, done_d;
    logic rdy_q, rdy_d;
    logic [7:0] cap_q, cap_d;
    logic push_v;
    logic fifo_in_ready;
    logic wrdy_q, wrdy_d;

    // Read data passes through a buffer so a stalled consumer stalls reads
    nfc_buf2 #(.W(8)) u_rbuf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(push_v),
        .in_ready(fifo_in_ready),
        .in_data(cap_q),
        .out_valid(rdata_valid),
        .out_ready(rdata_ready),
        .out_data(rdata)
    );

    assign push_v = (st_q == ST_PUSH);

    // First command byte of an operation
    function automatic logic [7:0] first_cmd(input nfc_req_t q);
        unique case (q.op)
            NFC_OP_READ: begin
                if (q.spare) begin
                    first_cmd = CMD_READ_SPARE;
                end else if (q.col >= 10'(HALF_COLS)) begin
                    first_cmd = CMD_READ_B;
                end else begin
                    first_cmd = CMD_READ_A;
                end
            end
            NFC_OP_READ_ID: first_cmd = CMD_READ_ID;
            NFC_OP_STATUS: first_cmd = CMD_STATUS;
            NFC_OP_PROG: first_cmd = CMD_PROG;
            NFC_OP_ERASE: first_cmd = CMD_ERASE;
            default: first_cmd = CMD_RESET;
        endcase
    endfunction

    // Number of address cycles per operation
    function automatic logic [1:0] addr_cycles(input nfc_op_t op);
        unique case (op)
            NFC_OP_READ, NFC_OP_PROG: addr_cycles = 2'd3;
            NFC_OP_ERASE: addr_cycles = 2'd2;
            NFC_OP_READ_ID: addr_cycles = 2'd1;
            default: addr_cycles = 2'd0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        logic strobe_end;
        st_d = st_q;
        r_d = r_q;
        pin_d = pin_q;
        out_d = out_q;
        oe_d = oe_q;
        idx_d = idx_q;
        tmr_d = (tmr_q != 4'd0) ? tmr_q - 4'd1 : 4'd0;
        ph_d = ph_q;
        left_d = left_q;
        done_d = 1'b0;
        rdy_d = 1'b0;
        cap_d = cap_q;
        strobe_end = (tmr_q == 4'd0);
        unique case (st_q)
            ST_IDLE: begin
                pin_d.cmd_latch = 1'b0;
                pin_d.addr_latch = 1'b0;
                oe_d = 1'b0;
                rdy_d = 1'b1;
                if (req_valid && rdy_q) begin
                    rdy_d = 1'b0;
                    r_d = req;
                    // only reset/status go out while busy
                    if (rb_s2_q || req.op == NFC_OP_RESET ||
                        req.op == NFC_OP_STATUS) begin
                        // spare enable follows request, kept static
                        pin_d.spare_access_n = ~req.spare;
                        pin_d.chip_sel_n = 1'b0;
                        pin_d.cmd_latch = 1'b1;
                        pin_d.write_strobe_n = 1'b0;
                        out_d = first_cmd(req);
                        oe_d = 1'b1;
                        tmr_d = STROBE_CYC4;
                        ph_d = 1'b0;
                        idx_d = 2'd0;
                        left_d = req.count;
                        st_d = ST_CMD;
                    end else begin
                        st_d = ST_FINISH;
                    end
                end
            end
            ST_CMD, ST_ADDR, ST_CMD2, ST_WDATA: begin
                if (strobe_end && !ph_q) begin
                    pin_d.write_strobe_n = 1'b1; // rising edge latches
                    ph_d = 1'b1;
                    tmr_d = STROBE_CYC4;
                end else if (strobe_end && ph_q) begin
                    pin_d.cmd_latch = 1'b0;
                    pin_d.addr_latch = 1'b0;
                    ph_d = 1'b0;
                    tmr_d = STROBE_CYC4;
                    if (st_q == ST_ADDR) begin
                        idx_d = idx_q + 2'd1;
                    end
                    if ((st_q == ST_CMD && addr_cycles(r_q.op) != 2'd0) ||
                        (st_q == ST_ADDR &&
                         idx_q + 2'd1 != addr_cycles(r_q.op))) begin
                        st_d = ST_ADDR;
                        pin_d.addr_latch = 1'b1;
                        pin_d.write_strobe_n = 1'b0;
                        out_d = (r_q.op == NFC_OP_ERASE) ? r_q.row[7:0]
                            : r_q.col[7:0];
                        if (st_q == ST_ADDR) begin
                            out_d = (idx_q == 2'd0 &&
                                     r_q.op != NFC_OP_ERASE)
                                ? r_q.row[7:0] : {1'b0, r_q.row[14:8]};
                        end
                    end else if (st_q == ST_WDATA && wdata_valid &&
                                 left_q > 10'd1) begin
                        left_d = left_q - 10'd1;
                        pin_d.write_strobe_n = 1'b0;
                        out_d = wdata;
                    end else if (r_q.op == NFC_OP_PROG &&
                                 st_q != ST_CMD2 && st_q != ST_WDATA &&
                                 left_q != 10'd0) begin
                        st_d = ST_WDATA; // page data into register
                        tmr_d = 4'd0;
                        ph_d = 1'b1;
                        left_d = left_q + 10'd1;
                    end else if ((r_q.op == NFC_OP_PROG ||
                                  r_q.op == NFC_OP_ERASE) &&
                                 st_q != ST_CMD2) begin
                        if (st_q != ST_WDATA || left_q <= 10'd1) begin
                            st_d = ST_CMD2;
                            pin_d.cmd_latch = 1'b1;
                            pin_d.write_strobe_n = 1'b0;
                            out_d = (r_q.op == NFC_OP_PROG) ? CMD_PROG_GO
                                                            : CMD_ERASE_GO;
                        end else begin
                            // Wait for write data
                            tmr_d = 4'd0;
                            ph_d = 1'b1;
                        end
                    end else begin
                        oe_d = 1'b0;
                        st_d = ST_WAIT_BSY;
                        tmr_d = 4'd4;
                    end
                end
            end
            ST_WAIT_BSY: begin
                if (strobe_end) begin
                    st_d = ST_WAIT_RDY;
                end
            end
            ST_WAIT_RDY: begin
                if (rb_s2_q || r_q.op == NFC_OP_STATUS) begin
                    if (r_q.op == NFC_OP_PROG || r_q.op == NFC_OP_ERASE ||
                        r_q.op == NFC_OP_RESET || left_q == 10'd0) begin
                        st_d = ST_FINISH;
                    end else begin
                        st_d = ST_RDATA;
                        pin_d.output_strobe_n = 1'b0;
                        tmr_d = 4'd3;
                        ph_d = 1'b0;
                    end
                end
            end
            ST_RDATA: begin
                if (strobe_end && !ph_q) begin
                    cap_d = bp_s2_q;
                    pin_d.output_strobe_n = 1'b1;
                    left_d = left_q - 10'd1;
                    st_d = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    if (left_q == 10'd0) begin
                        st_d = ST_FINISH;
                    end else begin
                        st_d = ST_RDATA; // next falling edge
                        pin_d.output_strobe_n = 1'b0;
                        tmr_d = 4'd3;
                    end
                end
            end
            ST_FINISH: begin
                // deselect after reads; next read resends 00h, 01h or 50h
                if (!(rb_s2_q == 1'b0 && (r_q.op == NFC_OP_PROG ||
                                          r_q.op == NFC_OP_ERASE))) begin
                    pin_d.chip_sel_n = 1'b1;
                end
                done_d = 1'b1;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
        wrdy_d = (st_d == ST_WDATA) && ph_d && (tmr_d == 4'd0) &&
                 (left_d > 10'd1);
    end

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            r_q <= '0;
            pin_q <= 6'h27;
            out_q <= 8'h00;
            oe_q <= 1'b0;
            idx_q <= 2'd0;
            tmr_q <= 4'd0;
            ph_q <= 1'b0;
            left_q <= 10'd0;
            done_q <= 1'b0;
            rdy_q <= 1'b0;
            cap_q <= 8'h00;
            wrdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            r_q <= r_d;
            pin_q <= pin_d;
            out_q <= out_d;
            oe_q <= oe_d;
            idx_q <= idx_d;
            tmr_q <= tmr_d;
            ph_q <= ph_d;
            left_q <= left_d;
            done_q <= done_d;
            rdy_q <= rdy_d;
            cap_q <= cap_d;
            wrdy_q <= wrdy_d;
        end
    end

    assign pins = pin_q;
    assign byte_port_o = out_q;
    assign byte_port_oe = oe_q;
    assign done = done_q;
    assign req_ready = rdy_q;
    assign wdata_ready = wrdy_q;
endmodule // nfc_host
`default_nettype wire

// ---- src/nfc_pkg.sv ----
package nfc_pkg;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_READ_A = 8'h00;
    localparam logic [7:0] CMD_READ_B = 8'h01;
    localparam logic [7:0] CMD_READ_SPARE = 8'h50;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_PROG = 8'h80;
    localparam logic [7:0] CMD_PROG_GO = 8'h10;
    localparam logic [7:0] CMD_ERASE = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_STATUS = 8'h70;

    // ----------------------------------------------------------------
    // Geometry and timing
    // ----------------------------------------------------------------
    localparam int PAGE_COLS = 528;
    localparam int HALF_COLS = 256;
    localparam int SPARE_BASE = 512;
    localparam int SPARE_LAST = 527;
    localparam int PAGES_PER_BLOCK = 32;
    localparam int BLOCKS = 1024;
    localparam int CLK_NS = 100;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] STROBE_CYC4 = 4'(STROBE_CYC);

    // ----------------------------------------------------------------
    // Operation kinds
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        NFC_OP_READ = 3'b000,
        NFC_OP_READ_ID = 3'b001,
        NFC_OP_STATUS = 3'b010,
        NFC_OP_PROG = 3'b011,
        NFC_OP_ERASE = 3'b100,
        NFC_OP_RESET = 3'b101
    } nfc_op_t;

    // Request from the user side
    typedef struct packed {
        nfc_op_t op;
        logic spare;      // read of the spare area (50h)
        logic [9:0] col;  // 0..527
        logic [14:0] row; // block and page
        logic [9:0] count; // bytes to move
    } nfc_req_t;

    // Pin group toward the flash
    typedef struct packed {
        logic chip_sel_n;
        logic cmd_latch;
        logic addr_latch;
        logic write_strobe_n;
        logic output_strobe_n;
        logic spare_access_n;
    } nfc_pins_t;
endpackage

// ---- verification/nfc_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Flash part model seen from its pins
// ----
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A, // Arbitrary value
    parameter int BUSY_NS = 2000
) (
    input wire nfc_pins_t pins,
    input wire logic [7:0] byte_port_o,
    input wire logic hold_busy,
    output logic [7:0] byte_port_i,
    output logic ready_busy_n
);
    logic [9:0] log_q[$];
    logic [7:0] pg[PAGE_COLS];
    logic [7:0] cmd = CMD_RESET;
    logic [7:0] last = 8'h00;
    logic [7:0] b;
    logic [7:0] rlo = 8'h00;
    logic [9:0] col = 10'h000;
    int na = 0;
    logic busy = 1'b0;
    logic drv = 1'b0;
    logic half = 1'b0;
    logic se_ok = 1'b0;
    // Busy window; a stale one may end early after a reset command
    task automatic run_busy();
        busy = 1'b1;
        #(BUSY_NS);
        busy = 1'b0;
    endtask
    // Released port shows the inverse of the last byte, not a held copy
    assign byte_port_i = drv ? last : ~last;
    assign ready_busy_n = !(busy || hold_busy);
    // Capture on the closing edge of the write strobe
    always @(posedge pins.write_strobe_n) begin
        b = byte_port_o;
        if (!pins.chip_sel_n && pins.cmd_latch) begin
            log_q.push_back({2'd1, b});
            if (ready_busy_n || b == CMD_STATUS || b == CMD_RESET) begin
                cmd = b;
                na = 0;
                if (b == CMD_READ_A || b == CMD_READ_B) half = b[0];
                se_ok = !pins.spare_access_n;
                if (b == CMD_PROG_GO || b == CMD_ERASE_GO) begin
                    fork run_busy(); join_none
                end
                if (b == CMD_RESET) busy = 1'b0;
            end
        end else if (!pins.chip_sel_n && pins.addr_latch) begin
            if (na == 2 || (cmd == CMD_ERASE && na == 1)) b[7] = 1'b0;
            log_q.push_back({2'd2, b});
            if (na == 0 && cmd != CMD_ERASE) begin
                col = cmd == CMD_READ_SPARE ? 10'(SPARE_BASE + b[3:0])
                    : {1'b0, half, b};
                half = 1'b0;
            end
            if (na == 1) rlo = b;
            if (na == 2 && cmd != CMD_PROG) begin
                for (int i = 0; i < PAGE_COLS; i++) pg[i] = 8'(i) ^ rlo;
                fork run_busy(); join_none
            end
            na = na + 1;
        end else if (!pins.chip_sel_n) begin
            log_q.push_back({2'd0, b});
            pg[col] = b;
            col = col + 10'd1;
        end
    end
    // Next byte on each falling read strobe; column steps by one
    always @(negedge pins.output_strobe_n) begin
        if (!pins.chip_sel_n) begin
            drv = 1'b1;
            if (cmd == CMD_READ_ID) last = ID_CODE;
            else if (cmd == CMD_STATUS) last = {1'b1, ready_busy_n, 6'h00};
            else if (cmd == CMD_READ_SPARE && !se_ok) last = 8'hFF;
            else last = pg[col];
            col = col + 10'd1;
        end
    end
    // Deselect or a new write releases the port
    always @(posedge pins.chip_sel_n or negedge pins.write_strobe_n) begin
        drv = 1'b0;
    end
endmodule // nfc_flash_model
`default_nettype wire

// ---- verification/nfc_host_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin protocol checks on the controller
// ----
module nfc_host_asserts
    import nfc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic rdata_valid,
    input wire logic rdata_ready,
    input wire logic done,
    input wire nfc_pins_t pins,
    input wire logic [7:0] byte_port_o,
    input wire logic byte_port_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Writes only toward a selected part, with the port driven
    a_write_selected: assert property (
        !pins.write_strobe_n |-> !pins.chip_sel_n && byte_port_oe)
        else $error("write strobe without select or drive");
    // Never both strobes low; the port has one direction at a time
    a_strobes_apart: assert property (
        !pins.output_strobe_n |-> pins.write_strobe_n)
        else $error("read and write strobes low together");
    a_latch_roles: assert property (
        pins.cmd_latch |-> !pins.addr_latch)
        else $error("command and address latch both high");
    // Qualifiers and byte must not move at the capturing edge
    a_latch_hold: assert property (
        $rose(pins.write_strobe_n) |-> $stable(pins.cmd_latch) &&
        $stable(pins.addr_latch) && $stable(byte_port_o))
        else $error("qualifier or byte moved at strobe rise");
    a_read_released: assert property (
        !pins.output_strobe_n |-> !byte_port_oe)
        else $error("port driven during read strobe");
    a_read_selected: assert property (
        !pins.output_strobe_n |-> !pins.chip_sel_n)
        else $error("read strobe while deselected");
    a_spare_enable: assert property (
        pins.cmd_latch && !pins.write_strobe_n &&
        byte_port_o == CMD_READ_SPARE |-> !pins.spare_access_n)
        else $error("spare read without spare enable low");
    // Spare enable is kept still while the part is selected
    a_spare_static: assert property (
        !pins.chip_sel_n && $past(!pins.chip_sel_n) |->
        $stable(pins.spare_access_n))
        else $error("spare enable toggled while selected");
    a_done_single: assert property (
        done |=> !done)
        else $error("done longer than one cycle");
    c_read: cover property (!pins.output_strobe_n);
    c_addr: cover property ($rose(pins.write_strobe_n) && pins.addr_latch);
    c_stall: cover property (rdata_valid && !rdata_ready);
endmodule // nfc_host_asserts

bind nfc_host nfc_host_asserts u_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .rdata_valid(rdata_valid),
    .rdata_ready(rdata_ready), .done(done), .pins(pins),
    .byte_port_o(byte_port_o), .byte_port_oe(byte_port_oe)
);
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Self-checking bench for the flash controller
// ----
module testbench;
    import nfc_pkg::*;
    localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary value
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    nfc_req_t req = '0;
    logic wdata_valid = 1'b0;
    logic wdata_ready;
    logic [7:0] wdata = 8'h00;
    logic rdata_valid;
    logic rdata_ready = 1'b0;
    logic [7:0] rdata;
    logic done;
    nfc_pins_t pins;
    logic [7:0] byte_port_o;
    logic byte_port_oe;
    logic [7:0] byte_port_i;
    logic ready_busy_n;
    logic hold_busy = 1'b0;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    int seed = 32'h6EA1F069;
    int error_cnt = 0;
    int total_checks = 0;
    int tn = 0;
    always #50 ref_clk = ~ref_clk;
    nfc_host DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .wdata_valid(wdata_valid),
        .wdata_ready(wdata_ready), .wdata(wdata), .rdata_valid(rdata_valid),
        .rdata_ready(rdata_ready), .rdata(rdata), .done(done), .pins(pins),
        .byte_port_o(byte_port_o), .byte_port_oe(byte_port_oe),
        .byte_port_i(byte_port_i), .ready_busy_n(ready_busy_n)
    );
    nfc_flash_model #(.ID_CODE(ID_VAL)) FLASH (
        .pins(pins), .byte_port_o(byte_port_o), .hold_busy(hold_busy),
        .byte_port_i(byte_port_i), .ready_busy_n(ready_busy_n)
    );
    // Data streams; the reader stalls at random to fill the buffer
    always @(posedge ref_clk) begin
        if (wdata_valid && wdata_ready) void'(wq.pop_front());
        if (rdata_valid && rdata_ready) rq.push_back(rdata);
        #1;
        wdata_valid = wq.size() > 0;
        wdata = wq.size() > 0 ? wq[0] : 8'h00;
        rdata_ready = 1'($random(seed));
    end
    task automatic check(input string what, input logic [9:0] seen,
                         input logic [9:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Mode 1: refused, so no pin traffic
    task automatic do_op(input nfc_op_t op, input logic sp,
            input logic [9:0] c, input logic [14:0] r,
            input logic [9:0] n, input int mode);
        logic [9:0] eq[$];
        logic [7:0] xd[$];
        logic [7:0] d;
        int k;
        int base;
        base = FLASH.log_q.size();
        rq.delete();
        case (op)
            NFC_OP_READ: begin
                d = sp ? CMD_READ_SPARE : c >= 10'd256 ? CMD_READ_B : CMD_READ_A;
                eq = '{{2'd1, d}, {2'd2, c[7:0]}, {2'd2, r[7:0]},
                       {2'd2, 1'b0, r[14:8]}};
                for (k = 0; k < n; k++) xd.push_back(8'(c + k) ^ r[7:0]);
            end
            NFC_OP_READ_ID: begin
                eq = '{{2'd1, CMD_READ_ID}, {2'd2, 8'h00}};
                xd = '{ID_VAL};
            end
            NFC_OP_STATUS: begin
                eq = '{{2'd1, CMD_STATUS}};
                xd = '{hold_busy ? 8'h80 : 8'hC0};
            end
            NFC_OP_RESET: eq = '{{2'd1, CMD_RESET}};
            NFC_OP_PROG: begin
                eq = '{{2'd1, CMD_PROG}, {2'd2, c[7:0]}, {2'd2, r[7:0]},
                       {2'd2, 1'b0, r[14:8]}};
                for (k = 0; k < n; k++) begin
                    d = 8'($random(seed));
                    wq.push_back(d);
                    eq.push_back({2'd0, d});
                end
                eq.push_back({2'd1, CMD_PROG_GO});
            end
            default: eq = '{{2'd1, CMD_ERASE}, {2'd2, r[7:0]},
                            {2'd2, 1'b0, r[14:8]}, {2'd1, CMD_ERASE_GO}};
        endcase
        if (mode == 1) begin
            eq.delete();
            xd.delete();
        end
        @(posedge ref_clk);
        #1;
        req = '{op: op, spare: sp, col: c, row: r, count: n};
        req_valid = 1'b1;
        for (k = 0; k < 1000 && req_ready !== 1'b1; k++) @(posedge ref_clk) #1;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge ref_clk) #1;
        check("done", {9'h000, done}, 10'h001);
        for (k = 0; k < 200 && (k < 12 || rdata_valid); k++)
            @(posedge ref_clk) #1;
        check("log count", 10'(FLASH.log_q.size() - base), 10'(eq.size()));
        foreach (eq[i]) check("pin byte", FLASH.log_q[base + i], eq[i]);
        check("read count", 10'(rq.size()), 10'(xd.size()));
        foreach (xd[i]) check("rd byte", 10'(rq[i]), 10'(xd[i]));
        tn++;
        $display("test %0d done", tn);
    endtask
    // Release a held busy line some time after the next request
    task automatic release_later();
        fork
            begin
                repeat (40) @(posedge ref_clk);
                #1;
                hold_busy = 1'b0;
            end
        join_none
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        do_op(NFC_OP_RESET, 1'b0, 10'd0, 15'h0000, 10'd0, 0);
        do_op(NFC_OP_READ_ID, 1'b0, 10'd0, 15'h0000, 10'd1, 0);
        do_op(NFC_OP_STATUS, 1'b0, 10'd0, 15'h0000, 10'd1, 0);
        do_op(NFC_OP_PROG, 1'b0, 10'd3, 15'h7F21, 10'd20, 0);
        do_op(NFC_OP_READ, 1'b0, 10'd5, 15'h7F21, 10'd12, 0);
        do_op(NFC_OP_READ, 1'b0, 10'd300, 15'h0123, 10'd6, 0);
        do_op(NFC_OP_READ, 1'b1, 10'd512, 15'h0042, 10'd16, 0);
        do_op(NFC_OP_ERASE, 1'b0, 10'd0, 15'h7FE0, 10'd0, 0);
        hold_busy = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        do_op(NFC_OP_READ, 1'b0, 10'd0, 15'h0011, 10'd4, 1);
        release_later();
        do_op(NFC_OP_STATUS, 1'b0, 10'd0, 15'h0000, 10'd1, 0);
        hold_busy = 1'b1;
        release_later();
        do_op(NFC_OP_RESET, 1'b0, 10'd0, 15'h0000, 10'd0, 0);
        tally_and_finish();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #(100 * 40000);
        error_cnt++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
